// *** hw/pm_csr_pkg.sv ***
package pm_csr_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [7:0] PM_DWORD_OFFSET = 8'h54; // dword holding both registers
   localparam logic [7:0] CSR_OFFSET      = 8'h54; // power_state_control_status
   localparam logic [7:0] BSE_OFFSET      = 8'h56; // bridge_power_support_ext
   localparam logic [7:0] DATA_OFFSET     = 8'h57; // unused data register, reads zero

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int WAKE_STAT_BIT    = 15;
   localparam int SCALE_HI_BIT     = 14;
   localparam int SCALE_LO_BIT     = 13;
   localparam int SELECT_HI_BIT    = 12;
   localparam int SELECT_LO_BIT    = 9;
   localparam int WAKE_EN_BIT      = 8;
   localparam int RSVD_HI_BIT      = 7;
   localparam int RSVD_LO_BIT      = 4;
   localparam int CTX_KEPT_BIT     = 3;
   localparam int RSVD_BIT         = 2;
   localparam int STATE_HI_BIT     = 1;
   localparam int STATE_LO_BIT     = 0;
   localparam int CLK_STOP_BIT     = 7;  // within the extension byte
   localparam int BUS_STATE_BIT    = 6;  // within the extension byte
   localparam int BSE_RSVD_HI_BIT  = 5;

   // ***************************************************************
   // reset values and constant fields
   // ***************************************************************
   localparam logic [15:0] CSR_RESET      = 16'h0000;
   localparam logic [7:0]  BSE_RESET      = 8'h40;
   localparam logic        WAKE_EN_RESET  = 1'h0;
   localparam logic        BUS_STATE_B2   = 1'h1;
   localparam logic [7:0]  DATA_REG_VALUE = 8'h00;

   // ***************************************************************
   // power states, in field encoding order
   // ***************************************************************
   typedef enum logic [1:0] {
      PWR_D0,
      PWR_D1,
      PWR_D2,
      PWR_D3HOT
   } power_state_t;

   // ***************************************************************
   // configuration access carriers
   // ***************************************************************
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic [31:0] rdata;
   } cfg_rsp_t;

endpackage

// *** hw/pm_state_reg.sv ***
`timescale 1ns/1ps
module pm_state_reg (
   // clock and reset
   input  wire logic                     i_core_clk,
   input  wire logic                     i_arst_n,
   // write strobes per byte lane
   input  wire logic                     i_wr_lane0,
   input  wire logic                     i_wr_lane1,
   input  wire logic [15:0]              i_wdata,
   // stored state
   output pm_csr_pkg::power_state_t      o_state,
   output logic                          o_wake_en
);

   // ***************************************************************
   // writable fields
   // ***************************************************************
   pm_csr_pkg::power_state_t state_ff;
   pm_csr_pkg::power_state_t nxt_state;
   logic                     wake_en_ff;
   logic                     nxt_wake_en;

   // every encoding is a supported state, so the cast cannot go illegal
   assign nxt_state   = i_wr_lane0 ?
                        pm_csr_pkg::power_state_t'(i_wdata[pm_csr_pkg::STATE_HI_BIT:
                                                           pm_csr_pkg::STATE_LO_BIT]) :
                        state_ff;
   assign nxt_wake_en = i_wr_lane1 ? i_wdata[pm_csr_pkg::WAKE_EN_BIT] : wake_en_ff;

   // only the async reset clears these; a D3hot to D0 move keeps them
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_ff   <= pm_csr_pkg::PWR_D0;
         wake_en_ff <= pm_csr_pkg::WAKE_EN_RESET;
      end else begin
         state_ff   <= nxt_state;
         wake_en_ff <= nxt_wake_en;
      end
   end

   assign o_state   = state_ff;
   assign o_wake_en = wake_en_ff;

endmodule

// *** hw/pm_read_mux.sv ***
`timescale 1ns/1ps
module pm_read_mux (
   // live field sources
   input  pm_csr_pkg::power_state_t i_state,
   input  wire logic                i_wake_en,
   input  wire logic                i_rev_select,
   input  wire logic                i_clk_stop_enable,
   // assembled dword
   output logic [31:0]              o_dword
);

   // ***************************************************************
   // field assembly
   // ***************************************************************
   logic [15:0] csr_word;
   logic [7:0]  bse_byte;

   // constant and reserved fields come from the reset images, never from a store
   always_comb begin
      csr_word = pm_csr_pkg::CSR_RESET;
      csr_word[pm_csr_pkg::WAKE_EN_BIT]  = i_wake_en;
      csr_word[pm_csr_pkg::CTX_KEPT_BIT] = i_rev_select;
      csr_word[pm_csr_pkg::STATE_HI_BIT:pm_csr_pkg::STATE_LO_BIT] = i_state;
      bse_byte = pm_csr_pkg::BSE_RESET;
      bse_byte[pm_csr_pkg::BUS_STATE_BIT] = pm_csr_pkg::BUS_STATE_B2;
      bse_byte[pm_csr_pkg::CLK_STOP_BIT]  = i_clk_stop_enable;
   end

   assign o_dword = {pm_csr_pkg::DATA_REG_VALUE, bse_byte, csr_word};

endmodule

// *** hw/power_mgmt_csr.sv ***
`timescale 1ns/1ps
module power_mgmt_csr (
   // clock and reset
   input  wire logic                     i_core_clk,
   input  wire logic                     i_arst_n,
   // configuration space access
   input  pm_csr_pkg::cfg_req_t          i_cfg_req,
   output pm_csr_pkg::cfg_rsp_t          o_cfg_rsp,
   // bits mirrored from the general control register
   input  wire logic                     i_pm_revision_select,
   input  wire logic                     i_secondary_clock_stop_enable,
   // power state towards the rest of the bridge
   output pm_csr_pkg::power_state_t      o_power_state,
   output logic                          o_secondary_clock_stop
);

   // ***************************************************************
   // address decode
   // ***************************************************************
   logic        dword_hit;
   logic        wr_lane0;
   logic        wr_lane1;
   logic        rd_hit;

   // low address bits are lane selects, so the dword compare drops them
   assign dword_hit = (i_cfg_req.addr[7:2] == pm_csr_pkg::PM_DWORD_OFFSET[7:2]);
   // lanes 2 and 3 hold only read-only bytes (constants and the mirrored clock stop bit), so writes there have no target
   assign wr_lane0  = i_cfg_req.wr & dword_hit & i_cfg_req.be[0];
   assign wr_lane1  = i_cfg_req.wr & dword_hit & i_cfg_req.be[1];
   assign rd_hit    = i_cfg_req.rd & dword_hit;

   // ***************************************************************
   // writable storage
   // ***************************************************************
   pm_csr_pkg::power_state_t state;
   logic                     wake_en;

   pm_state_reg u_state (
      .i_core_clk (i_core_clk),
      .i_arst_n   (i_arst_n),
      .i_wr_lane0 (wr_lane0),
      .i_wr_lane1 (wr_lane1),
      .i_wdata    (i_cfg_req.wdata[15:0]),
      .o_state    (state),
      .o_wake_en  (wake_en)
   );

   // ***************************************************************
   // read path
   // ***************************************************************
   logic [31:0] rd_dword;

   pm_read_mux u_mux (
      .i_state           (state),
      .i_wake_en         (wake_en),
      .i_rev_select      (i_pm_revision_select),
      .i_clk_stop_enable (i_secondary_clock_stop_enable),
      .o_dword           (rd_dword)
   );

   pm_csr_pkg::cfg_rsp_t rsp_ff;
   pm_csr_pkg::cfg_rsp_t nxt_rsp;
   logic                 clk_stop_ff;
   logic                 nxt_clk_stop;

   // every read gets one answer a cycle later; misses read as zero
   assign nxt_rsp.valid = i_cfg_req.rd;
   assign nxt_rsp.hit   = rd_hit;
   assign nxt_rsp.rdata = rd_hit ? rd_dword : 32'h0000_0000;

   // clocks stop only when both in D3hot and the enable says so
   assign nxt_clk_stop  = (state == pm_csr_pkg::PWR_D3HOT) &
                          i_secondary_clock_stop_enable;

   // answer and status registers
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rsp_ff      <= '0;
         clk_stop_ff <= 1'h0;
      end else begin
         rsp_ff      <= nxt_rsp;
         clk_stop_ff <= nxt_clk_stop;
      end
   end

   assign o_cfg_rsp              = rsp_ff;
   assign o_power_state          = state;
   assign o_secondary_clock_stop = clk_stop_ff;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   logic [15:0] rd_csr;
   logic [7:0]  rd_bse;
   assign rd_csr = o_cfg_rsp.rdata[15:0];
   assign rd_bse = o_cfg_rsp.rdata[23:16];

   logic hit_read;
   assign hit_read = o_cfg_rsp.valid & o_cfg_rsp.hit;

   // a D3hot to D0 move must leave the scratch bit alone
   ctx_kept_d0_a: assert property (
      ($past(state) == pm_csr_pkg::PWR_D3HOT) && (state == pm_csr_pkg::PWR_D0)
      && !$past(wr_lane1) |-> wake_en == $past(wake_en))
      else $error("context lost on D3hot to D0");

   wake_stat_zero_a: assert property (
      hit_read |-> rd_csr[pm_csr_pkg::WAKE_STAT_BIT] == 1'b0)
      else $error("wake status read nonzero");

   data_scale_zero_a: assert property (
      hit_read |-> rd_csr[pm_csr_pkg::SCALE_HI_BIT:pm_csr_pkg::SCALE_LO_BIT] == 2'h0)
      else $error("data scale read nonzero");

   data_select_zero_a: assert property (
      hit_read |-> rd_csr[pm_csr_pkg::SELECT_HI_BIT:pm_csr_pkg::SELECT_LO_BIT] == 4'h0)
      else $error("data select read nonzero");

   wake_en_rw_a: assert property (
      wr_lane1 ##1 (!wr_lane1 && i_cfg_req.rd && dword_hit)
      |-> ##1 rd_csr[pm_csr_pkg::WAKE_EN_BIT] == $past(i_cfg_req.wdata[8], 2))
      else $error("wake enable readback wrong");

   csr_rsvd_zero_a: assert property (
      hit_read |-> rd_csr[pm_csr_pkg::RSVD_HI_BIT:pm_csr_pkg::RSVD_LO_BIT] == 4'h0
      && rd_csr[pm_csr_pkg::RSVD_BIT] == 1'b0)
      else $error("reserved control bits nonzero");

   ctx_flag_a: assert property (
      hit_read |-> rd_csr[pm_csr_pkg::CTX_KEPT_BIT] == $past(i_pm_revision_select))
      else $error("context flag does not follow revision select");

   state_write_a: assert property (
      wr_lane0 |=> o_power_state == $past(i_cfg_req.wdata[1:0]))
      else $error("power state not taken from write");

   state_hold_a: assert property (
      !wr_lane0 |=> $stable(o_power_state))
      else $error("power state moved without write");

   state_readback_a: assert property (
      hit_read |-> rd_csr[pm_csr_pkg::STATE_HI_BIT:pm_csr_pkg::STATE_LO_BIT]
      == $past(state))
      else $error("power state readback wrong");

   clk_stop_mirror_a: assert property (
      hit_read |-> rd_bse[pm_csr_pkg::CLK_STOP_BIT]
      == $past(i_secondary_clock_stop_enable))
      else $error("clock stop bit not mirrored");

   clk_stop_out_a: assert property (
      (o_power_state == pm_csr_pkg::PWR_D3HOT) && i_secondary_clock_stop_enable
      ##1 $stable(o_power_state) |-> o_secondary_clock_stop)
      else $error("secondary clocks not stopped in D3");

   bus_state_b2_a: assert property (
      hit_read |-> rd_bse[pm_csr_pkg::BUS_STATE_BIT] == 1'b1)
      else $error("bus state bit not one");

   bse_rsvd_zero_a: assert property (
      hit_read |-> rd_bse[pm_csr_pkg::BSE_RSVD_HI_BIT:0] == 6'h00
      && o_cfg_rsp.rdata[31:24] == 8'h00)
      else $error("extension reserved bits nonzero");

   miss_zero_a: assert property (
      i_cfg_req.rd && !dword_hit |=> o_cfg_rsp.valid && !o_cfg_rsp.hit
      && o_cfg_rsp.rdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   // main scenarios
   enter_d3_c: cover property (
      o_power_state == pm_csr_pkg::PWR_D0 ##1 o_power_state == pm_csr_pkg::PWR_D3HOT);
   leave_d3_c: cover property (
      o_power_state == pm_csr_pkg::PWR_D3HOT ##1 o_power_state == pm_csr_pkg::PWR_D0);
   ctx_read_c: cover property (hit_read && rd_csr[pm_csr_pkg::CTX_KEPT_BIT]);
   clk_stop_c: cover property (o_secondary_clock_stop);

endmodule

// *** verification/power_mgmt_csr_tb.sv ***
`timescale 1ns/1ps
module power_mgmt_csr_tb;

   // ***************************************************************
   // clock, reset and design hookup
   // ***************************************************************
   logic                     i_core_clk;
   logic                     i_arst_n;
   pm_csr_pkg::cfg_req_t     req;
   pm_csr_pkg::cfg_rsp_t     rsp;
   logic                     rev;
   logic                     cse;
   pm_csr_pkg::power_state_t pstate;
   logic                     clk_stop;
   logic [1:0]               st_m;
   logic                     wake_m;
   logic [7:0]               addr_r;
   int                       n_fail;
   int                       tests_run;
   int                       cycles;

   power_mgmt_csr dut (
      .i_core_clk                    (i_core_clk),
      .i_arst_n                      (i_arst_n),
      .i_cfg_req                     (req),
      .o_cfg_rsp                     (rsp),
      .i_pm_revision_select          (rev),
      .i_secondary_clock_stop_enable (cse),
      .o_power_state                 (pstate),
      .o_secondary_clock_stop        (clk_stop)
   );

   // free-running 10 MHz clock
   initial i_core_clk = 1'b0;
   always #50 i_core_clk = ~i_core_clk;

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         summarize();
      end
   end

   // ***************************************************************
   // expectation and check helpers
   // ***************************************************************
   // whole dword at 0x54 worked out from the field layout
   function automatic logic [31:0] exp_dword(input logic [1:0] st, input logic wk,
                                             input logic rv, input logic cs);
      return {8'h00, cs, 1'b1, 6'h00, 7'h00, wk, 4'h0, rv, 1'b0, st};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle write; the model follows only the writable lanes of the hit dword
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
      @(negedge i_core_clk);
      if (a[7:2] == 6'h15) begin
         if (be[0]) st_m = d[1:0];
         if (be[1]) wake_m = d[8];
      end
   endtask

   // one-cycle read; answer sampled in the cycle after the taking edge
   task automatic cfg_read(input logic [7:0] a);
      logic hit_e;
      hit_e = (a[7:2] == 6'h15);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
      @(negedge i_core_clk);
      chk({30'h0, rsp.valid, rsp.hit}, {30'h0, 1'b1, hit_e});
      chk(rsp.rdata, hit_e ? exp_dword(st_m, wake_m, rev, cse) : 32'h0);
   endtask

   // idle cycle so strobes never get two values in one time step
   task automatic idle();
      req = '0;
      @(negedge i_core_clk);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      req = '0;
      rev = 1'b0;
      cse = 1'b0;
      i_arst_n = 1'b0;
      st_m = 2'h0;
      wake_m = 1'b0;
      addr_r = 8'h00;
      n_fail = 0;
      tests_run = 0;
      cycles = 0;
      void'($urandom(12857));
      repeat (16) @(negedge i_core_clk);
      i_arst_n = 1'b1;
      // reset values of both registers
      chk({30'h0, pstate}, 32'h0);
      chk({31'h0, clk_stop}, 32'h0);
      cfg_read(8'h54);
      $display("test reset_values done");
      // every state code, with read-only bits of lane 0 stuffed with ones
      cse = 1'b1;
      for (int s = 0; s < 4; s++) begin
         cfg_write(8'h54, 4'h1, 32'hFFFF_FFFC | 32'(s));
         chk({30'h0, pstate}, {30'h0, st_m});
         idle();
         chk({31'h0, clk_stop}, {31'h0, st_m == 2'h3});
         cfg_read(8'h56);
      end
      $display("test state_codes done");
      // leaving D3hot keeps the scratch bit: nothing is reset
      cfg_write(8'h54, 4'h2, 32'h0000_0100);
      cfg_write(8'h54, 4'h1, 32'h0000_0000);
      cfg_read(8'h54);
      $display("test d3hot_to_d0 done");
      // mirrored general control bits in all four combinations
      for (int k = 0; k < 4; k++) begin
         rev = k[0];
         cse = k[1];
         idle();
         cfg_read(8'h54);
      end
      $display("test mirrored_bits done");
      // all lanes written with ones; read-only bits must not move
      cfg_write(8'h57, 4'hF, 32'hFFFF_FFFF);
      cfg_read(8'h54);
      // write and read outside the dword: ignored, then a miss answer
      cfg_write(8'h58, 4'hF, 32'h0000_0000);
      cfg_read(8'h60);
      cfg_read(8'h54);
      $display("test lanes_and_misses done");
      // random traffic, back to back, half of it aimed at the dword
      repeat (60) begin
         addr_r = ($urandom % 2) ? (8'h54 | 8'($urandom % 4)) : 8'($urandom);
         cfg_write(addr_r, 4'($urandom), $urandom);
         rev = 1'($urandom);
         cse = 1'($urandom);
         cfg_read(addr_r);
         chk({31'h0, clk_stop}, {31'h0, (st_m == 2'h3) & cse});
      end
      $display("test random_traffic done");
      idle();
      summarize();
   end

endmodule
